// *** logic/fbim_input_bank.sv ***
/*
 Read-only input word bank seen by a fieldbus master on the secondary port.
 Holds the measured values, status flags and command readback, plus the
 set point source and output enable decisions that follow the command word with read-write port access (the enable
 also needing the digital enable input when that input is configured), else the digital or local inputs.
 Assumes the measurement front end, alarm logic and command holding word
 are synchronous to clk_in; the port adapter presents one access at a time.
*/
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Input words are read-only to the master; writes leave them unchanged.
// - Word index addresses word buses; byte offset is twice the index.
// - Measured values are unsigned and clamped to their documented maxima.
// - Words 2..5 carry frequency, voltage, current and power in their units.
// - Status bit 0 follows the shorted thyristor alarm.
// - Status bit 1 follows the load open-circuit alarm.
// - Status bit 2 shows whether the power output is enabled.
// - Status bit 4 follows the current-limit alarm.
// - Status bit 5 momentary thermal alarm; bit 15 latched thermal alarm.
// - Latched thermal bit holds until the latch is cleared.
// - Status bit 6 follows the communication alarm.
// - Status bit 8 follows digital input one.
// - Status bit 9 follows digital input two.
// - Status bit 10 follows the phase-imbalance alarm.
// - Status bit 14 shows heater bakeout running.
// - Command readback bit 1 shows local set point source.
// - Command readback bit 2 shows output enable command.
// - Command readback bit 4 shows local current limit source.
// - With read-write port access, set point source follows command bit 1 only.
// - With read-write access and enable input, enable needs input and command bit 2.
module fbim_input_bank (
   input  wire logic                  clk_in,
   input  wire logic                  rstn_in,
   // Access from the port adapter
   input  wire fbim_pkg::fbim_acc_e   acc_in,
   input  wire logic                  byte_mode_in,
   input  wire logic [6:0]            addr_in,
   input  wire logic [15:0]           wdata_in,
   output logic      [15:0]           rdata_out,
   output logic                       rvalid_out,
   output logic                       werr_out,
   // Measurements
   input  wire logic [15:0]           freq_in,
   input  wire logic [15:0]           volt_in,
   input  wire logic [15:0]           curr_in,
   input  wire logic [15:0]           power_in,
   // Alarms and inputs
   input  wire logic                  scr_short_in,
   input  wire logic                  load_open_in,
   input  wire logic                  cur_lim_alarm_in,
   input  wire logic                  thermal_in,
   input  wire logic                  thermal_latch_clr_in,
   input  wire logic                  comm_alarm_in,
   input  wire logic                  din1_in,
   input  wire logic                  din2_in,
   input  wire logic                  unbal_alarm_in,
   input  wire logic                  bakeout_in,
   // Command word and configuration
   input  wire logic [15:0]           cmd_word_in,
   input  wire logic                  port_rw_in,
   input  wire logic                  din_sp_cfg_in,
   input  wire logic                  din_sp_level_in,
   input  wire logic                  din_en_cfg_in,
   input  wire logic                  din_en_level_in,
   input  wire logic                  local_sp_in,
   input  wire logic                  local_en_in,
   output logic                       sp_local_out,
   output logic                       out_enable_out
);
   import fbim_pkg::*;

   // ==========================================================
   // Address decode
   function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] mx);
      clamp16 = (v > mx) ? mx : v;
   endfunction : clamp16

   wire logic [5:0]  word_idx;
   wire logic        addr_odd;
   wire logic        hit_read;
   assign word_idx = byte_mode_in ? addr_in[6:1] : addr_in[5:0];
   assign addr_odd = byte_mode_in ? addr_in[0] : addr_in[6];
   assign hit_read = (acc_in == FBIM_ACC_READ);

   // ==========================================================
   // Control decisions
   wire logic sp_local_d;
   wire logic out_en_d;
   // Digital input ignored for the source once the port can write
   assign sp_local_d = port_rw_in ? cmd_word_in[FBIM_CMD_SP_LOCAL]
                     : (din_sp_cfg_in ? din_sp_level_in : local_sp_in);
   assign out_en_d   = port_rw_in
                     ? (din_en_cfg_in ? (din_en_level_in && cmd_word_in[FBIM_CMD_OUT_EN])
                                      : cmd_word_in[FBIM_CMD_OUT_EN])
                     : (din_en_cfg_in ? din_en_level_in : local_en_in);

   logic sp_local_q;
   logic out_en_q;
   logic th_latch_q;
   logic th_latch_d;
   // Set wins over a clear in the same cycle
   assign th_latch_d = thermal_in ? 1'b1 : (thermal_latch_clr_in ? 1'b0 : th_latch_q);

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sp_local_q <= 1'b0;
         out_en_q   <= 1'b0;
         th_latch_q <= 1'b0;
      end else begin
         sp_local_q <= sp_local_d;
         out_en_q   <= out_en_d;
         th_latch_q <= th_latch_d;
      end
   end
   assign sp_local_out   = sp_local_q;
   assign out_enable_out = out_en_q;

   // ==========================================================
   // Word assembly
   logic [15:0] status_w;
   logic [15:0] cmd_w;
   always_comb begin
      status_w = FBIM_RESET_WORD;
      status_w[FBIM_ST_SCR_SHORT] = scr_short_in;
      status_w[FBIM_ST_LOAD_OPEN] = load_open_in;
      status_w[FBIM_ST_OUT_EN]    = out_en_q;
      status_w[FBIM_ST_CUR_LIM]   = cur_lim_alarm_in;
      status_w[FBIM_ST_THERMAL]   = thermal_in;
      status_w[FBIM_ST_COMM]      = comm_alarm_in;
      status_w[FBIM_ST_DIN1]      = din1_in;
      status_w[FBIM_ST_DIN2]      = din2_in;
      status_w[FBIM_ST_UNBAL]     = unbal_alarm_in;
      status_w[FBIM_ST_BAKEOUT]   = bakeout_in;
      status_w[FBIM_ST_TH_LATCH]  = th_latch_q;
   end
   assign cmd_w = cmd_word_in & FBIM_CMD_USED_MASK;

   wire logic [15:0] rd_word;
   // Odd byte offsets are not word aligned and read zero
   assign rd_word =
        addr_odd                    ? FBIM_RESET_WORD
      : (word_idx == FBIM_IDX_FREQ)  ? clamp16(freq_in,  FBIM_MAX_FREQ)
      : (word_idx == FBIM_IDX_VOLT)  ? clamp16(volt_in,  FBIM_MAX_VOLT)
      : (word_idx == FBIM_IDX_CURR)  ? clamp16(curr_in,  FBIM_MAX_CURR)
      : (word_idx == FBIM_IDX_POWER) ? clamp16(power_in, FBIM_MAX_POWER)
      : (word_idx == FBIM_IDX_STATUS)? status_w
      : (word_idx == FBIM_IDX_CMD)   ? cmd_w
      : FBIM_RESET_WORD;

   // ==========================================================
   // Read answer; writes only flagged, never stored
   logic [15:0] rdata_q;
   logic        rvalid_q;
   logic        werr_q;
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rdata_q  <= FBIM_RESET_WORD;
         rvalid_q <= 1'b0;
         werr_q   <= 1'b0;
      end else begin
         rvalid_q <= hit_read;
         werr_q   <= (acc_in == FBIM_ACC_WRITE);
         if (hit_read) begin
            rdata_q <= rd_word;
         end
      end
   end
   assign rdata_out  = rdata_q;
   assign rvalid_out = rvalid_q;
   assign werr_out   = werr_q;

   // ==========================================================
   // Checks
   wire logic [6:0] stat_byte;
   assign stat_byte = {FBIM_IDX_STATUS, 1'b0};
   // Aligned read of a real word, shared by the per-word checks below
   wire logic       rd_ok;
   assign rd_ok = hit_read && !addr_odd;

   latch_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      th_latch_q && !thermal_latch_clr_in |=> th_latch_q)
      else $error("latched thermal bit dropped without clear");
   latch_set_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      thermal_in |=> th_latch_q)
      else $error("latched thermal bit not set");
   write_quiet_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      acc_in == FBIM_ACC_WRITE |=> !rvalid_out && $stable(rdata_out))
      else $error("write disturbed read data");
   unused_zero_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      hit_read && !addr_odd && word_idx <= FBIM_IDX_UNUSED1 |=> rdata_out == 16'h0000)
      else $error("unused word not zero");
   power_bound_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      hit_read && !addr_odd && word_idx == FBIM_IDX_POWER |=> rdata_out <= FBIM_MAX_POWER)
      else $error("power above bound");
   volt_bound_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      hit_read && !addr_odd && word_idx == FBIM_IDX_VOLT |=> rdata_out <= FBIM_MAX_VOLT)
      else $error("voltage above bound");
   status_rsvd_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      hit_read && !addr_odd && word_idx == FBIM_IDX_STATUS
      |=> (rdata_out & ~FBIM_ST_USED_MASK) == 16'h0000)
      else $error("unused status bit set");
   status_flags_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      hit_read && !addr_odd && word_idx == FBIM_IDX_STATUS
      |=> rdata_out[FBIM_ST_DIN1] == $past(din1_in)
          && rdata_out[FBIM_ST_SCR_SHORT] == $past(scr_short_in))
      else $error("status flag mismatch");
   byte_map_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      hit_read && byte_mode_in && addr_in == stat_byte
      |=> rdata_out[FBIM_ST_COMM] == $past(comm_alarm_in))
      else $error("byte offset 12 not status");
   cmd_rb_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      hit_read && !addr_odd && word_idx == FBIM_IDX_CMD
      |=> rdata_out == ($past(cmd_word_in) & FBIM_CMD_USED_MASK))
      else $error("command readback mismatch");
   sp_follow_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      port_rw_in |=> sp_local_out == $past(cmd_word_in[FBIM_CMD_SP_LOCAL]))
      else $error("set point source ignores command");
   en_both_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      port_rw_in && din_en_cfg_in && !din_en_level_in |=> !out_enable_out)
      else $error("enabled without digital input");
   en_status_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      hit_read && !addr_odd && word_idx == FBIM_IDX_STATUS
      |=> rdata_out[FBIM_ST_OUT_EN] == $past(out_en_q))
      else $error("enable status mismatch");

   // ==========================================================
   // Per-word content checks
   freq_word_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      rd_ok && word_idx == FBIM_IDX_FREQ
      |=> rdata_out == $past(freq_in))
      else $error("frequency word mismatch");
   volt_word_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      rd_ok && word_idx == FBIM_IDX_VOLT
      |=> rdata_out == (($past(volt_in) > FBIM_MAX_VOLT) ? FBIM_MAX_VOLT : $past(volt_in)))
      else $error("voltage word mismatch");
   power_word_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      rd_ok && word_idx == FBIM_IDX_POWER
      |=> rdata_out == (($past(power_in) > FBIM_MAX_POWER) ? FBIM_MAX_POWER : $past(power_in)))
      else $error("power word mismatch");
   curr_bound_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      rd_ok && word_idx == FBIM_IDX_CURR
      |=> rdata_out <= FBIM_MAX_CURR)
      else $error("current above bound");

   // ==========================================================
   // Status bit checks
   load_open_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      rd_ok && word_idx == FBIM_IDX_STATUS
      |=> rdata_out[FBIM_ST_LOAD_OPEN] == $past(load_open_in))
      else $error("load open bit mismatch");
   cur_lim_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      rd_ok && word_idx == FBIM_IDX_STATUS
      |=> rdata_out[FBIM_ST_CUR_LIM] == $past(cur_lim_alarm_in))
      else $error("current limit bit mismatch");
   thermal_now_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      rd_ok && word_idx == FBIM_IDX_STATUS
      |=> rdata_out[FBIM_ST_THERMAL] == $past(thermal_in))
      else $error("thermal bit mismatch");
   latch_status_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      rd_ok && word_idx == FBIM_IDX_STATUS
      |=> rdata_out[FBIM_ST_TH_LATCH] == $past(th_latch_q))
      else $error("latched thermal bit mismatch");
   latch_clear_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      thermal_latch_clr_in && !thermal_in
      |=> !th_latch_q)
      else $error("latch not cleared");
   comm_flag_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      rd_ok && word_idx == FBIM_IDX_STATUS
      |=> rdata_out[FBIM_ST_COMM] == $past(comm_alarm_in))
      else $error("communication bit mismatch");
   din_two_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      rd_ok && word_idx == FBIM_IDX_STATUS
      |=> rdata_out[FBIM_ST_DIN2] == $past(din2_in))
      else $error("second input bit mismatch");
   unbal_flag_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      rd_ok && word_idx == FBIM_IDX_STATUS
      |=> rdata_out[FBIM_ST_UNBAL] == $past(unbal_alarm_in))
      else $error("imbalance bit mismatch");
   bakeout_flag_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      rd_ok && word_idx == FBIM_IDX_STATUS
      |=> rdata_out[FBIM_ST_BAKEOUT] == $past(bakeout_in))
      else $error("bakeout bit mismatch");
   word_map_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      hit_read && !byte_mode_in && addr_in == {1'b0, FBIM_IDX_STATUS}
      |=> rdata_out[FBIM_ST_DIN1] == $past(din1_in))
      else $error("word index 6 not status");

   // ==========================================================
   // Command readback checks
   sp_readback_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      rd_ok && word_idx == FBIM_IDX_CMD
      |=> rdata_out[FBIM_CMD_SP_LOCAL] == $past(cmd_word_in[FBIM_CMD_SP_LOCAL]))
      else $error("set point source bit mismatch");
   il_readback_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      rd_ok && word_idx == FBIM_IDX_CMD
      |=> rdata_out[FBIM_CMD_IL_LOCAL] == $past(cmd_word_in[FBIM_CMD_IL_LOCAL]))
      else $error("current limit source bit mismatch");
   cmd_rsvd_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      rd_ok && word_idx == FBIM_IDX_CMD
      |=> (rdata_out & ~FBIM_CMD_USED_MASK) == 16'h0000)
      else $error("unused command bit set");

   // ==========================================================
   // Access handshake checks, then the output enable follow check
   odd_zero_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      hit_read && addr_odd
      |=> rdata_out == 16'h0000)
      else $error("odd offset not zero");
   read_pulse_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      hit_read
      |=> rvalid_out && !werr_out)
      else $error("read answer missing");
   write_flag_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      acc_in == FBIM_ACC_WRITE
      |=> werr_out)
      else $error("write not flagged");
   idle_quiet_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      acc_in == FBIM_ACC_NONE
      |=> !rvalid_out && !werr_out)
      else $error("answer without request");
   en_follow_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      port_rw_in && din_en_cfg_in && din_en_level_in && cmd_word_in[FBIM_CMD_OUT_EN]
      |=> out_enable_out)
      else $error("enable missing with both on");

   cov_status_read: cover property (@(posedge clk_in) disable iff (!rstn_in)
      hit_read && word_idx == FBIM_IDX_STATUS ##1 rvalid_out);
   cov_latch_clear: cover property (@(posedge clk_in) disable iff (!rstn_in)
      th_latch_q ##1 thermal_latch_clr_in ##1 !th_latch_q);
   cov_write_try: cover property (@(posedge clk_in) disable iff (!rstn_in)
      acc_in == FBIM_ACC_WRITE ##1 werr_out);
   cov_en_both: cover property (@(posedge clk_in) disable iff (!rstn_in)
      port_rw_in && din_en_cfg_in && din_en_level_in ##1 out_enable_out);
   cov_sp_local: cover property (@(posedge clk_in) disable iff (!rstn_in)
      port_rw_in && cmd_word_in[FBIM_CMD_SP_LOCAL] ##1 sp_local_out);
endmodule : fbim_input_bank
`default_nettype wire

// *** logic/fbim_pkg.sv ***
/*
 Package for the fieldbus input word bank: word indices, status and command
 bit positions, value bounds and access codes.
 Assumes one 25 MHz clock domain; used by fbim_input_bank, the master model and the bench.
*/
`default_nettype none
package fbim_pkg;
   localparam int unsigned  FBIM_IDX_W        = 6;
   localparam int unsigned  FBIM_WORD_W       = 16;
   localparam logic [5:0]   FBIM_IDX_UNUSED0  = 6'h00;
   localparam logic [5:0]   FBIM_IDX_UNUSED1  = 6'h01;
   localparam logic [5:0]   FBIM_IDX_FREQ     = 6'h02;
   localparam logic [5:0]   FBIM_IDX_VOLT     = 6'h03;
   localparam logic [5:0]   FBIM_IDX_CURR     = 6'h04;
   localparam logic [5:0]   FBIM_IDX_POWER    = 6'h05;
   localparam logic [5:0]   FBIM_IDX_STATUS   = 6'h06;
   localparam logic [5:0]   FBIM_IDX_CMD      = 6'h07;
   localparam logic [15:0]  FBIM_MAX_FREQ     = 16'hffff;
   localparam logic [15:0]  FBIM_MAX_VOLT     = 16'h270f;
   localparam logic [15:0]  FBIM_MAX_CURR     = 16'h270f;
   localparam logic [15:0]  FBIM_MAX_POWER    = 16'h0064;
   localparam logic [15:0]  FBIM_RESET_WORD   = 16'h0000;
   localparam int unsigned  FBIM_ST_SCR_SHORT = 0;
   localparam int unsigned  FBIM_ST_LOAD_OPEN = 1;
   localparam int unsigned  FBIM_ST_OUT_EN    = 2;
   localparam int unsigned  FBIM_ST_CUR_LIM   = 4;
   localparam int unsigned  FBIM_ST_THERMAL   = 5;
   localparam int unsigned  FBIM_ST_COMM      = 6;
   localparam int unsigned  FBIM_ST_DIN1      = 8;
   localparam int unsigned  FBIM_ST_DIN2      = 9;
   localparam int unsigned  FBIM_ST_UNBAL     = 10;
   localparam int unsigned  FBIM_ST_BAKEOUT   = 14;
   localparam int unsigned  FBIM_ST_TH_LATCH  = 15;
   localparam int unsigned  FBIM_CMD_SP_LOCAL = 1;
   localparam int unsigned  FBIM_CMD_OUT_EN   = 2;
   localparam int unsigned  FBIM_CMD_IL_LOCAL = 4;
   localparam logic [15:0]  FBIM_ST_USED_MASK = 16'hc777;
   localparam logic [15:0]  FBIM_CMD_USED_MASK = 16'h0016;
   typedef enum logic [1:0] {
      FBIM_ACC_NONE  = 2'b00,
      FBIM_ACC_READ  = 2'b01,
      FBIM_ACC_WRITE = 2'b11
   } fbim_acc_e;
endpackage : fbim_pkg
`default_nettype wire

// *** verification/fbim_master_model.sv ***
/*
 Fieldbus master model: presents one word access per call of access().
 Assumes the bank takes a request at the first edge that sees it.
*/
`timescale 1ns/10ps
`default_nettype none
module fbim_master_model (
   input  wire logic                 clk_in,
   output var  fbim_pkg::fbim_acc_e  acc_out,
   output var  logic                 byte_mode_out,
   output var  logic [6:0]           addr_out,
   output var  logic [15:0]          wdata_out
);
   import fbim_pkg::*;
   initial begin
      acc_out       = FBIM_ACC_NONE;
      byte_mode_out = 1'b0;
      addr_out      = 7'h55;
      wdata_out     = 16'h0000;
   end
   // ==========================================================
   // Access cycle
   task automatic access(input logic wr, input logic bm, input logic [5:0] idx,
                         input logic [15:0] wd);
      @(posedge clk_in);
      acc_out       <= wr ? FBIM_ACC_WRITE : FBIM_ACC_READ;
      byte_mode_out <= bm;
      addr_out      <= bm ? {idx, 1'b0} : {1'b0, idx};
      wdata_out     <= wd;
      @(posedge clk_in);
      // Request drops to none; address and data toggle so their stale values are never relied on
      acc_out       <= FBIM_ACC_NONE;
      addr_out      <= ~addr_out;
      wdata_out     <= ~wd;
   endtask : access
endmodule : fbim_master_model
`default_nettype wire

// *** verification/fbim_input_bank_tb.sv ***
/*
 Self-checking bench for the input word bank, reads and writes via the master model.
 Assumes a one-cycle read answer and registered control outputs.
*/
`timescale 1ns/10ps
`default_nettype none
module fbim_input_bank_tb;
   import fbim_pkg::*;
   logic        clk_in, rstn_in, lat_clr, port_rw, sp_cfg, sp_lvl, en_cfg, en_lvl;
   logic        loc_sp, loc_en, lat, en;
   logic [15:0] freq, volt, curr, power, cmd, st, rdata_out;
   logic [8:0]  flg;
   logic        rvalid_out, werr_out, sp_local_out, out_enable_out, bm;
   logic [6:0]  addr;
   logic [15:0] wdata;
   fbim_acc_e   acc;
   logic [31:0] seed;
   logic [16:0] exp_q[$];
   logic [16:0] e;
   int          error_cnt, num_checks, cyc;
   always #20 clk_in = ~clk_in;
   fbim_master_model i_fbim_master_model (.clk_in(clk_in), .acc_out(acc),
      .byte_mode_out(bm), .addr_out(addr), .wdata_out(wdata));
   fbim_input_bank i_fbim_input_bank (.clk_in(clk_in), .rstn_in(rstn_in), .acc_in(acc),
      .byte_mode_in(bm), .addr_in(addr), .wdata_in(wdata), .rdata_out(rdata_out),
      .rvalid_out(rvalid_out), .werr_out(werr_out), .freq_in(freq), .volt_in(volt),
      .curr_in(curr), .power_in(power), .scr_short_in(flg[0]), .load_open_in(flg[1]),
      .cur_lim_alarm_in(flg[2]), .thermal_in(flg[3]), .thermal_latch_clr_in(lat_clr),
      .comm_alarm_in(flg[4]), .din1_in(flg[5]), .din2_in(flg[6]), .unbal_alarm_in(flg[7]),
      .bakeout_in(flg[8]), .cmd_word_in(cmd), .port_rw_in(port_rw), .din_sp_cfg_in(sp_cfg),
      .din_sp_level_in(sp_lvl), .din_en_cfg_in(en_cfg), .din_en_level_in(en_lvl),
      .local_sp_in(loc_sp), .local_en_in(loc_en), .sp_local_out(sp_local_out),
      .out_enable_out(out_enable_out));
   // ==========================================================
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
   endfunction : lfsr
   function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] m);
      return (v > m) ? m : v;
   endfunction : clamp
   task automatic check(input logic [15:0] seen, input logic [15:0] expv);
      num_checks++;
      if (seen !== expv) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expv);
      end
   endtask : check
   task automatic rd(input logic b, input logic [5:0] idx, input logic [15:0] ev);
      exp_q.push_back({1'b0, ev});
      i_fbim_master_model.access(1'b0, b, idx, ev ^ 16'h5a5a);
   endtask : rd
   task automatic wr(input logic b, input logic [5:0] idx, input logic [15:0] wd);
      exp_q.push_back({1'b1, 16'h0000});
      i_fbim_master_model.access(1'b1, b, idx, wd);
   endtask : wr
   task automatic conclude();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : conclude
   // ==========================================================
   // Result monitor: every answer pulse takes the oldest note
   always @(negedge clk_in) begin
      if (rvalid_out === 1'b1 || werr_out === 1'b1) begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 17'h1ffff;
         check({14'h0, werr_out, rvalid_out}, {14'h0, e[16], ~e[16]});
         if (e[16] === 1'b0) begin
            check(rdata_out, e[15:0]);
         end
      end
   end
   // Hang guard, well above the roughly 200 cycles the run needs
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 4000) begin
         error_cnt++;
         conclude();
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      clk_in = 1'b0; rstn_in = 1'b0; {freq, volt, curr, power} = '0; cmd = 16'h0016;
      flg = '0; lat_clr = 1'b0; port_rw = 1'b1; sp_cfg = 1'b1; sp_lvl = 1'b0;
      en_cfg = 1'b1; en_lvl = 1'b1; loc_sp = 1'b0; loc_en = 1'b0; lat = 1'b0;
      seed = 32'hb33c; error_cnt = 0; num_checks = 0; cyc = 0;
      repeat (8) @(posedge clk_in);
      rstn_in <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         freq  <= seed[31:16];
         volt  <= {2'b00, seed[13:0]};
         curr  <= {2'b00, seed[15:2]};
         power <= {8'h00, seed[23:16]};
         rd(i[0], FBIM_IDX_UNUSED0, 16'h0000);
         rd(i[0], FBIM_IDX_UNUSED1, 16'h0000);
         rd(i[0], FBIM_IDX_FREQ, seed[31:16]);
         rd(i[0], FBIM_IDX_VOLT, clamp({2'b00, seed[13:0]}, FBIM_MAX_VOLT));
         rd(i[0], FBIM_IDX_CURR, clamp({2'b00, seed[15:2]}, FBIM_MAX_CURR));
         rd(i[0], FBIM_IDX_POWER, clamp({8'h00, seed[23:16]}, FBIM_MAX_POWER));
         wr(i[0], FBIM_IDX_FREQ, ~seed[31:16]);
         rd(i[1], FBIM_IDX_FREQ, seed[31:16]);
      end
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         flg    <= seed[8:0] | ((i == 0) ? 9'h008 : 9'h000);
         cmd    <= seed[31:16];
         en_lvl <= seed[10];
         sp_lvl <= ~seed[17];
         lat = lat | seed[3] | (i == 0);
         en  = seed[10] & seed[18];
         st  = {lat, seed[8], 3'b000, seed[7:5], 1'b0, seed[4], seed[3] | (i == 0),
                seed[2], 1'b0, en, seed[1:0]};
         repeat (2) @(posedge clk_in);
         @(negedge clk_in);
         check({15'h0, sp_local_out}, {15'h0, seed[17]});
         check({15'h0, out_enable_out}, {15'h0, en});
         rd(i[0], FBIM_IDX_STATUS, st);
         rd(i[1], FBIM_IDX_CMD, seed[31:16] & 16'h0016);
      end
      @(posedge clk_in);
      flg     <= '0;
      lat_clr <= 1'b1;
      @(posedge clk_in);
      lat_clr <= 1'b0;
      @(posedge clk_in);
      rd(1'b0, FBIM_IDX_STATUS, {13'h0000, en, 2'b00});
      port_rw <= 1'b0;
      sp_cfg  <= 1'b0;
      en_cfg  <= 1'b0;
      loc_sp  <= 1'b1;
      loc_en  <= 1'b1;
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      check({15'h0, sp_local_out}, 16'h0001);
      check({15'h0, out_enable_out}, 16'h0001);
      repeat (4) @(posedge clk_in);
      check(exp_q.size(), 16'h0000);
      conclude();
   end
endmodule : fbim_input_bank_tb
`default_nettype wire
